// ===== rtl/emp_cfg.svh
// Constants for the external memory pin front end: widths, idle pin levels and clock figures.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EMP_CFG_SVH
`define EMP_CFG_SVH

`define EMP_ADDR_W       26
`define EMP_DATA_W       16
`define EMP_EXT_ADDR_W   24
`define EMP_BANK_W       2
`define EMP_BE_W         2
`define EMP_TIME_W       4
`define EMP_LAT_W        2
`define EMP_BYTE_W       8
`define EMP_EXT_ADDR_LSB 2
`define EMP_SYS_CLK_NS   8
`define EMP_SYS_DIV      2
`define EMP_PIN_OFF      1'h1
`define EMP_BE_OFF       2'h3
`define EMP_BE_BOTH      2'h0
`define EMP_BE_LANE0     2'h2
`define EMP_BE_LANE1     2'h1
`define EMP_TIME_ZERO    4'h0
`define EMP_TIME_ONE     4'h1
`define EMP_LAT_ZERO     2'h0
`define EMP_LAT_ONE      2'h1

`endif

// ===== rtl/emp_pkg.sv
// Types shared by the external memory pin front end and its bench.
// Assumes emp_cfg.svh is on the include path.
`include "emp_cfg.svh"

package emp_pkg;

  typedef enum logic [2:0] {
    EMP_ST_IDLE   = 3'b000,
    EMP_ST_SETUP  = 3'b001,
    EMP_ST_STROBE = 3'b010,
    EMP_ST_HOLD   = 3'b011,
    EMP_ST_SCMD   = 3'b100,
    EMP_ST_SLAT   = 3'b101
  } emp_state_e;

  // One access from the on-chip fabric; addr is a byte address inside the chosen space.
  typedef struct packed {
    logic                     space;   // 0 = space_a, 1 = space_b.
    logic                     write;   // 1 = write.
    logic                     half;    // 1 = 16-bit transfer, 0 = byte.
    logic [`EMP_ADDR_W-1:0]   addr;
    logic [`EMP_DATA_W-1:0]   wdata;
  } emp_req_s;

  // Per-space configuration.
  typedef struct packed {
    logic                     sync_mode;  // 1 = synchronous device.
    logic                     wide16;     // 1 = 16-bit device, 0 = 8-bit.
    logic                     sel_strobe; // Async select-strobe mode.
    logic                     ext_wait;   // Async ready input honoured.
    logic                     rd_enable;  // Sync strobe pin acts as read enable.
    logic [`EMP_TIME_W-1:0]   setup;
    logic [`EMP_TIME_W-1:0]   strobe;
    logic [`EMP_TIME_W-1:0]   hold;
    logic [`EMP_LAT_W-1:0]    rd_lat;
    logic [`EMP_LAT_W-1:0]    wr_lat;
  } emp_cfg_s;

endpackage

// ===== rtl/emp_pin_if.sv
// External memory pin front end: takes fabric accesses and plays them on the memory pins.
// Assumes requests arrive on i_clk and the external clock pin is unrelated in phase.
//
// What this block does
// - The port clock source, internal or external pin, is captured during reset and then fixed.
// - The memory clock output runs at the frequency of the selected port clock.
// - With the internal source, the port clock is half the internal system clock.
// - The data bus is 16 bits and serves 8-bit devices on the low lane and 16-bit devices.
// - Byte lane enables go low only for the lanes taking part, on reads and writes.
// - Two chip-select spaces, each with its own select, each async or sync.
// - The async range over both spaces is at most 128 megabytes.
// - A low ready input during an enabled wait stretches the strobe phase.
// - The sync strobe pin is address strobe when read enable select is 0, read enable when 1.
// - The bank address pins carry low-order address bits in both modes: both pins for 8-bit devices, the upper pin only for 16-bit.
// - Each space has its own read and write latency and its own async cycle timing.
// - Async spaces offer select-strobe mode and extended waits, little-endian only.
// - For 16-bit devices the upper bank pin carries address bit 1 and the lower stays 0; for 8-bit both carry 1:0.
`timescale 1ns/1ps
`default_nettype none
`include "emp_cfg.svh"

module emp_pin_if (
  input  wire logic                          i_clk,                    // Internal system clock.
  input  wire logic                          i_rst_n,                  // Sync reset, active low.
  input  wire logic                          i_ext_clock_in,           // External clock pin.
  input  wire logic                          i_clk_src_ext,            // Strap: 1 = pin clock.
  input  wire logic                          i_req_valid,              // Fabric request valid.
  output logic                               o_req_ready,              // Request taken.
  input  wire emp_pkg::emp_req_s             i_req,                    // Request contents.
  output logic                               o_rsp_valid,              // Access done pulse.
  output logic [`EMP_DATA_W-1:0]             o_rsp_rdata,              // Read data.
  input  wire emp_pkg::emp_cfg_s             i_cfg_space_a,            // Space a setup.
  input  wire emp_pkg::emp_cfg_s             i_cfg_space_b,            // Space b setup.
  output logic                               o_busy,                   // Access in progress.
  output logic                               o_clk_src_ext,            // Captured source.
  output logic                               o_memory_clock_out,       // Memory clock.
  output logic [`EMP_EXT_ADDR_W-1:0]         o_ext_address_bus,        // Address pins.
  output logic [`EMP_BANK_W-1:0]             o_bank_address_bits,      // Bank address pins.
  output logic [`EMP_BE_W-1:0]               o_byte_lane_enables_n,    // Byte enables.
  output logic                               o_chip_select_space_a_n,  // Select, space a.
  output logic                               o_chip_select_space_b_n,  // Select, space b.
  output logic                               o_read_not_write,         // High on reads.
  output logic                               o_output_enable_n,        // Output enable.
  output logic                               o_write_strobe_n,         // Write strobe.
  output logic                               o_sync_strobe_n,          // Addr strobe/read en.
  input  wire logic [`EMP_DATA_W-1:0]        i_ext_data_bus,           // Data pins in.
  output logic [`EMP_DATA_W-1:0]             o_ext_data_bus,           // Data pins out.
  output logic                               o_ext_data_bus_oe,        // Data pins driven.
  input  wire logic                          i_async_ready_in          // Ready, active high.
);
  import emp_pkg::*;

  logic                       src_s1;
  logic                       src_s2;
  logic                       src_ext_reg;
  logic                       div_reg;
  logic                       xrst_s1;
  logic                       xrst_s2;
  logic                       xtgl_reg;
  logic                       tg_s1;
  logic                       tg_s2;
  logic                       tg_s3;
  logic                       rdy_s1;
  logic                       rdy_s2;
  logic [`EMP_DATA_W-1:0]     dat_s1;
  logic [`EMP_DATA_W-1:0]     dat_s2;
  logic                       tick;
  emp_state_e                 state_reg;
  logic [`EMP_TIME_W-1:0]     cnt_reg;
  logic                       beat_reg;
  logic                       lane_reg;
  emp_req_s                   req_reg;
  emp_cfg_s                   cfg_reg;
  emp_req_s                   cur_req;
  emp_cfg_s                   cur_cfg;
  emp_state_e                 st_ld;
  logic [`EMP_TIME_W-1:0]     cnt_ld;
  logic [`EMP_LAT_W-1:0]      lat;
  logic [`EMP_ADDR_W-1:0]     ld_addr;
  logic                       ld_beat;
  logic                       ld_lane;
  logic                       take;
  logic                       fin;
  logic                       last;
  logic                       ld;
  logic                       setup_end;
  logic                       strobe_end;
  logic                       sel_mode;
  logic                       rsp_valid_reg;
  logic [`EMP_DATA_W-1:0]     rdata_reg;
  logic [`EMP_EXT_ADDR_W-1:0] addr_reg;
  logic [`EMP_BANK_W-1:0]     bank_reg;
  logic [`EMP_BE_W-1:0]       be_n_reg;
  logic                       cs_a_n_reg;
  logic                       cs_b_n_reg;
  logic                       rnw_reg;
  logic                       oe_n_reg;
  logic                       we_n_reg;
  logic                       sstb_n_reg;
  logic [`EMP_DATA_W-1:0]     dout_reg;
  logic                       doe_reg;

  function automatic logic [`EMP_TIME_W-1:0] tload(input logic [`EMP_TIME_W-1:0] v);
    tload = (v == `EMP_TIME_ZERO) ? `EMP_TIME_ZERO : v - `EMP_TIME_ONE;
  endfunction

  // The strap passes two flops and is frozen at the last reset edge.
  always_ff @(posedge i_clk) begin
    src_s1 <= i_clk_src_ext;
    src_s2 <= src_s1;
    if (!i_rst_n) begin
      src_ext_reg <= src_s2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || src_ext_reg) begin
      div_reg <= 1'h0;
    end else begin
      div_reg <= ~div_reg;
    end
  end

  // Pin clock domain: a free toggle whose edges mark port clock periods.
  always_ff @(posedge i_ext_clock_in) begin
    xrst_s1 <= i_rst_n;
    xrst_s2 <= xrst_s1;
    if (!xrst_s2) begin
      xtgl_reg <= 1'h0;
    end else begin
      xtgl_reg <= ~xtgl_reg;
    end
  end

  // Input synchronisers. The data bus is held by the device through the strobe, so two flops
  // only add latency; strobe widths must cover it.
  always_ff @(posedge i_clk) begin
    tg_s1  <= xtgl_reg;
    tg_s2  <= tg_s1;
    tg_s3  <= tg_s2;
    rdy_s1 <= i_async_ready_in;
    rdy_s2 <= rdy_s1;
    dat_s1 <= i_ext_data_bus;
    dat_s2 <= dat_s1;
  end

  // Pins change once per port clock period; with the internal source, on its falling edge.
  assign tick = src_ext_reg ? (tg_s2 ^ tg_s3) : div_reg;
  // Forwarding the pin clock keeps its frequency exactly; the divider gives half rate.
  assign o_memory_clock_out = src_ext_reg ? i_ext_clock_in : div_reg;

  always_comb begin
    cur_req  = (state_reg == EMP_ST_IDLE) ? i_req : req_reg;
    if (state_reg == EMP_ST_IDLE) begin
      cur_cfg = i_req.space ? i_cfg_space_b : i_cfg_space_a;
    end else begin
      cur_cfg = cfg_reg;
    end
    take     = (state_reg == EMP_ST_IDLE) && tick && i_req_valid;
    lat      = cur_req.write ? cur_cfg.wr_lat : cur_cfg.rd_lat;
    last     = cur_cfg.wide16 || !cur_req.half || beat_reg;
    fin      = tick && (((state_reg == EMP_ST_HOLD) && (cnt_reg == `EMP_TIME_ZERO))
                     || ((state_reg == EMP_ST_SCMD) && (lat == `EMP_LAT_ZERO))
                     || ((state_reg == EMP_ST_SLAT) && (cnt_reg == `EMP_TIME_ZERO)));
    ld       = take || (fin && !last);
    ld_beat  = !take;
    ld_addr  = cur_req.addr;
    if (!cur_cfg.wide16 && cur_req.half) begin
      ld_addr[0] = ld_beat;
    end
    ld_lane  = cur_req.half ? ld_beat : cur_req.addr[0];
    st_ld    = cur_cfg.sync_mode ? EMP_ST_SCMD : EMP_ST_SETUP;
    cnt_ld   = cur_cfg.sync_mode ? `EMP_TIME_ZERO : tload(cur_cfg.setup);
    sel_mode = cur_cfg.sel_strobe && !cur_cfg.sync_mode;
    setup_end  = tick && (state_reg == EMP_ST_SETUP) && (cnt_reg == `EMP_TIME_ZERO);
    strobe_end = tick && (state_reg == EMP_ST_STROBE) && (cnt_reg == `EMP_TIME_ZERO)
               && !(cur_cfg.ext_wait && !rdy_s2);
  end

  assign o_req_ready = take;

  // Sequencer.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= EMP_ST_IDLE;
      cnt_reg   <= `EMP_TIME_ZERO;
      beat_reg  <= 1'h0;
      lane_reg  <= 1'h0;
      req_reg   <= '0;
      cfg_reg   <= '0;
    end else if (tick) begin
      if (take) begin
        req_reg <= i_req;
        cfg_reg <= cur_cfg;
      end
      if (ld) begin
        beat_reg <= ld_beat;
        lane_reg <= ld_lane;
      end
      case (state_reg)
        EMP_ST_IDLE: begin
          if (take) begin
            state_reg <= st_ld;
            cnt_reg   <= cnt_ld;
          end
        end
        EMP_ST_SETUP: begin
          if (setup_end) begin
            state_reg <= EMP_ST_STROBE;
            cnt_reg   <= tload(cur_cfg.strobe);
          end else begin
            cnt_reg <= cnt_reg - `EMP_TIME_ONE;
          end
        end
        EMP_ST_STROBE: begin
          if (cnt_reg != `EMP_TIME_ZERO) begin
            cnt_reg <= cnt_reg - `EMP_TIME_ONE;
          end else if (strobe_end) begin
            state_reg <= EMP_ST_HOLD;
            cnt_reg   <= tload(cur_cfg.hold);
          end
        end
        EMP_ST_SCMD: begin
          if (fin) begin
            state_reg <= last ? EMP_ST_IDLE : st_ld;
            cnt_reg   <= cnt_ld;
          end else begin
            state_reg <= EMP_ST_SLAT;
            cnt_reg   <= {{(`EMP_TIME_W-`EMP_LAT_W){1'h0}}, lat - `EMP_LAT_ONE};
          end
        end
        EMP_ST_HOLD, EMP_ST_SLAT: begin
          if (fin) begin
            state_reg <= last ? EMP_ST_IDLE : st_ld;
            cnt_reg   <= cnt_ld;
          end else begin
            cnt_reg <= cnt_reg - `EMP_TIME_ONE;
          end
        end
        default: begin
          state_reg <= EMP_ST_IDLE;
          cnt_reg   <= `EMP_TIME_ZERO;
        end
      endcase
    end
  end

  // Pin drivers. Later assignments win: phase edges, then the return to idle, then a new load.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_reg   <= '0;
      bank_reg   <= '0;
      be_n_reg   <= `EMP_BE_OFF;
      cs_a_n_reg <= `EMP_PIN_OFF;
      cs_b_n_reg <= `EMP_PIN_OFF;
      rnw_reg    <= `EMP_PIN_OFF;
      oe_n_reg   <= `EMP_PIN_OFF;
      we_n_reg   <= `EMP_PIN_OFF;
      sstb_n_reg <= `EMP_PIN_OFF;
      dout_reg   <= '0;
      doe_reg    <= 1'h0;
    end else if (tick) begin
      if (setup_end) begin
        oe_n_reg <= cur_req.write;
        we_n_reg <= !cur_req.write;
        if (sel_mode) begin
          cs_a_n_reg <= cur_req.space;
          cs_b_n_reg <= !cur_req.space;
        end
      end
      if (strobe_end) begin
        oe_n_reg <= `EMP_PIN_OFF;
        we_n_reg <= `EMP_PIN_OFF;
        if (sel_mode) begin
          cs_a_n_reg <= `EMP_PIN_OFF;
          cs_b_n_reg <= `EMP_PIN_OFF;
        end
      end
      if ((state_reg == EMP_ST_SCMD) && !fin) begin
        we_n_reg   <= `EMP_PIN_OFF;
        oe_n_reg   <= cur_req.write;
        sstb_n_reg <= !(cur_cfg.rd_enable && !cur_req.write);
      end
      if (fin) begin
        be_n_reg   <= `EMP_BE_OFF;
        cs_a_n_reg <= `EMP_PIN_OFF;
        cs_b_n_reg <= `EMP_PIN_OFF;
        oe_n_reg   <= `EMP_PIN_OFF;
        we_n_reg   <= `EMP_PIN_OFF;
        sstb_n_reg <= `EMP_PIN_OFF;
        doe_reg    <= 1'h0;
      end
      if (ld) begin
        addr_reg <= ld_addr[`EMP_ADDR_W-1:`EMP_EXT_ADDR_LSB];
        if (cur_cfg.wide16) begin
          bank_reg <= {ld_addr[1], 1'h0};
          if (cur_req.half) begin
            be_n_reg <= `EMP_BE_BOTH;
          end else begin
            be_n_reg <= ld_addr[0] ? `EMP_BE_LANE1 : `EMP_BE_LANE0;
          end
          dout_reg <= cur_req.wdata;
        end else begin
          bank_reg <= ld_addr[1:0];
          be_n_reg <= `EMP_BE_LANE0;
          dout_reg <= {{`EMP_BYTE_W{1'h0}},
                       ld_lane ? cur_req.wdata[`EMP_DATA_W-1:`EMP_BYTE_W]
                               : cur_req.wdata[`EMP_BYTE_W-1:0]};
        end
        cs_a_n_reg <= cur_req.space || sel_mode;
        cs_b_n_reg <= !cur_req.space || sel_mode;
        rnw_reg    <= !cur_req.write;
        doe_reg    <= cur_req.write;
        oe_n_reg   <= `EMP_PIN_OFF;
        we_n_reg   <= !(cur_cfg.sync_mode && cur_req.write);
        // Address strobe marks every command; as read enable it marks reads only.
        sstb_n_reg <= !(cur_cfg.sync_mode && (!cur_cfg.rd_enable || !cur_req.write));
      end
    end
  end

  // Read capture and the answer to the fabric.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_reg     <= '0;
      rsp_valid_reg <= 1'h0;
    end else begin
      rsp_valid_reg <= fin && last;
      if (!cur_req.write && (strobe_end || (fin && cur_cfg.sync_mode))) begin
        if (cur_cfg.wide16) begin
          rdata_reg <= dat_s2;
        end else if (lane_reg) begin
          rdata_reg[`EMP_DATA_W-1:`EMP_BYTE_W] <= dat_s2[`EMP_BYTE_W-1:0];
        end else begin
          rdata_reg[`EMP_BYTE_W-1:0] <= dat_s2[`EMP_BYTE_W-1:0];
        end
      end
    end
  end

  assign o_rsp_valid             = rsp_valid_reg;
  assign o_rsp_rdata             = rdata_reg;
  assign o_busy                  = (state_reg != EMP_ST_IDLE);
  assign o_clk_src_ext           = src_ext_reg;
  assign o_ext_address_bus       = addr_reg;
  assign o_bank_address_bits     = bank_reg;
  assign o_byte_lane_enables_n   = be_n_reg;
  assign o_chip_select_space_a_n = cs_a_n_reg;
  assign o_chip_select_space_b_n = cs_b_n_reg;
  assign o_read_not_write        = rnw_reg;
  assign o_output_enable_n       = oe_n_reg;
  assign o_write_strobe_n        = we_n_reg;
  assign o_sync_strobe_n         = sstb_n_reg;
  assign o_ext_data_bus          = dout_reg;
  assign o_ext_data_bus_oe       = doe_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_setup_done;
    tick && (state_reg == EMP_ST_SETUP) && (cnt_reg == `EMP_TIME_ZERO);
  endsequence

  sequence s_strobe_live;
    (state_reg == EMP_ST_STROBE) && (!o_output_enable_n || !o_write_strobe_n);
  endsequence

  sequence s_final_hold;
    tick && (state_reg == EMP_ST_HOLD) && (cnt_reg == `EMP_TIME_ZERO) && last;
  endsequence

  chk_src_fixed: assert property ($past(i_rst_n) |-> $stable(src_ext_reg))
    else $error("clock source changed after reset");

  chk_half_rate: assert property (!src_ext_reg && $past(i_rst_n) |->
    (div_reg != $past(div_reg)) && (tick == div_reg))
    else $error("internal port clock not at half rate");

  chk_idle_quiet: assert property ((state_reg == EMP_ST_IDLE) && $past(i_rst_n) |->
    o_chip_select_space_a_n && o_chip_select_space_b_n && o_output_enable_n
    && o_write_strobe_n && (o_byte_lane_enables_n == `EMP_BE_OFF) && !o_ext_data_bus_oe)
    else $error("pins active while idle");

  chk_one_space: assert property (o_chip_select_space_a_n || o_chip_select_space_b_n)
    else $error("both chip selects active");

  chk_wait_stall: assert property (tick && (state_reg == EMP_ST_STROBE)
    && (cnt_reg == `EMP_TIME_ZERO) && cur_cfg.ext_wait && !rdy_s2
    |=> s_strobe_live)
    else $error("strobe ended while ready low");

  chk_setup_strobe: assert property (s_setup_done |=> s_strobe_live)
    else $error("strobe not started after setup");

  chk_hold_answer: assert property (s_final_hold |=> o_rsp_valid && !o_busy ##1 !o_rsp_valid)
    else $error("answer missing after final hold");

  chk_narrow_lane: assert property (o_busy && !cfg_reg.wide16 && !o_byte_lane_enables_n[0]
    |-> o_byte_lane_enables_n[1] && !o_ext_data_bus[`EMP_DATA_W-1])
    else $error("8-bit device used upper lane");

  chk_bank_wide: assert property (o_busy && cfg_reg.wide16 && !o_byte_lane_enables_n[0]
    |-> !o_bank_address_bits[0] && (o_bank_address_bits[1] == $past(ld_addr[1], 1) || !$past(ld)))
    else $error("wide device bank pins wrong");

  chk_addr_strobe: assert property (take && cur_cfg.sync_mode && !cur_cfg.rd_enable
    |=> !o_sync_strobe_n && (state_reg == EMP_ST_SCMD))
    else $error("address strobe not asserted for command");

  // The address strobe covers one port clock only, unless the next beat reloads it.
  chk_strobe_drop: assert property (tick && (state_reg == EMP_ST_SCMD)
    && !cfg_reg.rd_enable && (last || !fin) |=> o_sync_strobe_n)
    else $error("address strobe held past command cycle");

  chk_ready_taken: assert property (o_req_ready |=> o_busy)
    else $error("taken request left block idle");

endmodule // emp_pin_if

`default_nettype wire

// ===== test/emp_mem_model.sv
// Behavioural external memory standing on the pins of the front end, one array with a half per select.
// Assumes the front end forwards a running memory clock and puts address and strobes on it.
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  input  wire logic        i_mem_clk,  // Memory clock from the front end.
  input  wire logic        i_slow,     // Hold ready low in reads.
  input  wire logic        i_wide_b,   // Space b device is 16 bits.
  input  wire logic [23:0] i_addr,     // Address pins.
  input  wire logic [1:0]  i_bank,     // Bank pins.
  input  wire logic [1:0]  i_be_n,     // Byte enables.
  input  wire logic        i_cs_a_n,   // Select a.
  input  wire logic        i_cs_b_n,   // Select b.
  input  wire logic        i_rnw,      // High on reads.
  input  wire logic        i_we_n,     // Write strobe.
  input  wire logic [15:0] i_wdata,    // Data from the front end.
  output logic      [15:0] o_rdata,    // Data to the front end.
  output logic             o_ready     // Ready, active high.
);
  logic [7:0] mem [0:511];
  logic [8:0] idx;
  logic [3:0] wait_cnt = 4'h0;
  logic       sel;
  logic       wide;
  initial o_rdata = 16'h5a5a;
  assign sel  = ~(i_cs_a_n & i_cs_b_n);
  assign wide = i_cs_b_n | i_wide_b;
  assign idx  = {~i_cs_b_n, i_addr[5:0], i_bank[1], wide ? 1'b0 : i_bank[0]};
  always @(posedge i_mem_clk) begin
    if (sel && !i_we_n && !i_be_n[0]) mem[idx] <= i_wdata[7:0];
    if (sel && !i_we_n && !i_be_n[1] && wide) mem[idx | 9'h1] <= i_wdata[15:8];
    wait_cnt <= (sel && i_rnw) ? wait_cnt + 4'h1 : 4'h0;
    // A released bus flips every cycle so a late capture cannot pass by luck.
    o_rdata <= (sel && i_rnw) ? {mem[idx | 9'h1], mem[idx]} : ~o_rdata;
  end
  assign o_ready = !(i_slow && sel && wait_cnt < 4'h7);
endmodule // emp_mem_model
`default_nettype wire

// ===== test/tb.sv
// Bench for the external memory pin front end: a table of accesses, then timing cases.
// Assumes emp_mem_model stands on the pins and rtl is on the include path.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import emp_pkg::*;
  typedef struct packed {
    logic sp; logic wr; logic hf; logic [7:0] ad;
    logic [15:0] wd; logic [15:0] rd; logic [3:0] pin;
  } emp_row_s;
  logic clk = 0, eclk = 0, rst_n = 0, src = 0, valid = 0, slow = 0;
  logic rdy, rsp_v, busy, src_q, mclk, rnw, oe_n, we_n, ss_n, cs_a_n, cs_b_n, doe, ardy;
  logic [15:0] rdata, dout, din, mdat;
  logic [23:0] ea;
  logic [1:0]  ba, be_n;
  emp_req_s req = '0;
  emp_cfg_s cfg_a = {5'b01010, 4'h1, 4'h3, 4'h1, 2'h1, 2'h0};
  emp_cfg_s cfg_b = {5'b00100, 4'h1, 4'h3, 4'h1, 2'h1, 2'h0};
  int failures = 0, checked = 0, n0, n1, lows, rises;
  emp_row_s rows [8] = '{
    {3'b011, 8'h10, 16'ha55a, 16'ha55a, 4'h0}, {3'b001, 8'h10, 16'h0, 16'ha55a, 4'h0},
    {3'b010, 8'h13, 16'h7700, 16'h7700, 4'h9}, {3'b000, 8'h13, 16'h0, 16'h7700, 4'h9},
    {3'b111, 8'h20, 16'h1234, 16'h1234, 4'h2}, {3'b101, 8'h20, 16'h0, 16'h1234, 4'h2},
    {3'b110, 8'h25, 16'h5600, 16'h5600, 4'h6}, {3'b100, 8'h25, 16'h0, 16'h5600, 4'h6}};
  initial forever #4 clk = ~clk;
  initial forever #7.5 eclk = ~eclk;
  always @(posedge mclk) rises++;
  assign din = doe ? dout : mdat;
  emp_pin_if emp_pin_if_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_ext_clock_in(eclk), .i_clk_src_ext(src),
    .i_req_valid(valid), .o_req_ready(rdy), .i_req(req), .o_rsp_valid(rsp_v),
    .o_rsp_rdata(rdata), .i_cfg_space_a(cfg_a), .i_cfg_space_b(cfg_b), .o_busy(busy),
    .o_clk_src_ext(src_q), .o_memory_clock_out(mclk), .o_ext_address_bus(ea),
    .o_bank_address_bits(ba), .o_byte_lane_enables_n(be_n),
    .o_chip_select_space_a_n(cs_a_n), .o_chip_select_space_b_n(cs_b_n),
    .o_read_not_write(rnw), .o_output_enable_n(oe_n), .o_write_strobe_n(we_n),
    .o_sync_strobe_n(ss_n), .i_ext_data_bus(din), .o_ext_data_bus(dout),
    .o_ext_data_bus_oe(doe), .i_async_ready_in(ardy));
  emp_mem_model emp_mem_model_inst (
    .i_mem_clk(mclk), .i_slow(slow), .i_wide_b(cfg_b.wide16), .i_addr(ea), .i_bank(ba),
    .i_be_n(be_n), .i_cs_a_n(cs_a_n), .i_cs_b_n(cs_b_n), .i_rnw(rnw), .i_we_n(we_n),
    .i_wdata(dout), .o_rdata(mdat), .o_ready(ardy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic access(input emp_row_s r, output int n);
    logic       got;
    logic [3:0] pin;
    got = 0;
    pin = 4'hf;
    n = 0;
    lows = 0;
    @(negedge clk);
    req = {r.sp, r.wr, r.hf, 18'h0, r.ad, r.wd};
    valid = 1'b1;
    // Ready decodes valid combinationally, so let it settle before the first look.
    #1;
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(rdy, 1'b1);
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (rsp_v !== 1'b1 && n < 300) begin
      if (!got && (r.sp ? cs_b_n : cs_a_n) === 1'b0) begin
        got = 1;
        pin = {ba, be_n};
        chk(ea, {18'h0, r.ad[7:2]});
      end
      lows += (ss_n === 1'b0);
      @(negedge clk);
      n++;
    end
    chk(rsp_v, 1'b1);
    chk(pin, r.pin);
    chk({cs_a_n, cs_b_n, oe_n, we_n, be_n}, 6'h3f);
    if (!r.wr) chk(rdata & (r.hf ? 16'hffff : r.ad[0] ? 16'hff00 : 16'h00ff), r.rd);
  endtask
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (5) @(negedge clk);
    chk({cs_a_n, cs_b_n, oe_n, we_n, be_n, doe, busy, rsp_v, mclk}, 10'h3f0);
    rst_n = 1'b1;
    foreach (rows[i]) access(rows[i], n0);
    rises = 0;
    repeat (20) @(negedge clk);
    chk(rises, 10);
    chk(src_q, 1'b0);
    access(rows[1], n0);
    slow = 1'b1;
    access(rows[1], n1);
    slow = 1'b0;
    chk(n1 > n0 + 2, 1);
    for (int re = 0; re < 2; re++) begin
      cfg_b = {4'b1100, re[0], 4'h1, 4'h1, 4'h1, 2'h1, 2'h0};
      access({3'b111, 8'h40, 16'h9c3e, 16'h9c3e, 4'h0}, n0);
      access({3'b101, 8'h40, 16'h0, 16'h9c3e, 4'h0}, n0);
      chk(lows, re ? 4 : 2);
    end
    // A second reset moves the port onto the pin clock; the strap is then changed back.
    rst_n = 1'b0;
    src = 1'b1;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    src = 1'b0;
    rises = 0;
    #300;
    chk(rises, 20);
    chk(src_q, 1'b1);
    access(rows[1], n0);
    end_sim;
  end
endmodule // tb
`default_nettype wire
